// [pkg/crs_pkg.sv]
// package for the contactless receive status and collision register group
// assumes one clock domain and a byte-wide register port driven by host software
package crs_pkg;

   // ==========================================================
   // register offsets
   localparam logic [7:0] crs_addr_error = 8'h0a;     // error flags, read only
   localparam logic [7:0] crs_addr_link_status = 8'h0b;
   localparam logic [7:0] crs_addr_rx_bit_ctrl = 8'h0c;
   localparam logic [7:0] crs_addr_rx_coll = 8'h0d;
   localparam logic [7:0] crs_addr_irq_status = 8'h20; // sticky events, write one to clear
   localparam logic [7:0] crs_addr_irq_mask = 8'h21;   // same layout as status

   // ==========================================================
   // field positions
   localparam int crs_pos_cipher = 5;       // link_status cipher_active
   localparam int crs_pos_keep = 7;         // keep_bits_after_collision
   localparam int crs_pos_offset_lo = 4;    // first_bit_offset low bit
   localparam int crs_pos_coll_integ = 3;   // collision_as_integrity_error
   localparam int crs_pos_coll_valid = 7;   // collision_position_valid
   localparam int crs_pos_err_coll = 2;     // collision_detected in error reg
   localparam int crs_pos_err_integ = 0;    // integrity_error in error reg
   localparam int crs_pos_ev_done = 0;      // irq: reception finished
   localparam int crs_pos_ev_coll = 1;      // irq: collision seen
   localparam int crs_pos_ev_integ = 2;     // irq: integrity error
   localparam int crs_pos_ev_byte = 3;      // irq: byte stored

   // ==========================================================
   // reset values
   localparam logic [7:0] crs_rst_rx_bit_ctrl = 8'h00;
   localparam logic [3:0] crs_rst_irq_mask = 4'h0;

   // ==========================================================
   // transceiver state codes and limits
   localparam logic [2:0] crs_st_idle = 3'h0;
   localparam logic [2:0] crs_st_unused = 3'h4;     // never reported
   localparam logic [7:0] crs_coll_pos_max = 8'h3f; // last reportable position

   // receive phase of the bit assembler
   typedef enum logic {crs_rx_idle, crs_rx_active} crs_rx_phase_e;

   // bit stream from the receive decoder
   typedef struct packed {
      logic start;      // reception begins, one-cycle pulse
      logic bit_valid;  // one data bit present
      logic bit_value;  // resolved value of that bit
      logic bit_coll;   // collision detected on that bit
      logic integ_err;  // parity or crc error pulse
      logic done;       // end of reception pulse
   } crs_rx_in_s;

   // assembled byte towards the buffer
   typedef struct packed {
      logic valid;
      logic [7:0] data;
   } crs_byte_s;

endpackage : crs_pkg

// [hdl/crs_rx_status.sv]
// register group for receive status, bit alignment and collision position
// assumes the receive decoder delivers bits synchronously to clock
//
// The strobed register port was left to the implementer.
`timescale 1ns/10ps

// Function
// - report transceiver state, code 100b never shown
// - cipher flag bit 5; write zero clears
// - only authentication sets cipher flag
// - keep off: bits after collision stored zero
// - offset field places first received bit
// - offset seven wraps second bit to next byte
// - offset zero byte-oriented, otherwise bit-oriented
// - collision raises integrity error when enabled
// - last byte valid bits, zero means whole
// - valid bits loaded at end when bit-oriented, cleared at start
// - position valid flag only for valid position
// - position is zero-based first collided data bit
// - positions only up to 3fh reported
// - nonzero offset added into collision position
// - collision flag set, cleared at receive start
// - integrity flag set, reception continues
module crs_rx_status (
   input wire logic clock,
   input wire logic nrst,
   input wire logic [7:0] bus_addr,
   input wire logic [7:0] bus_wdata,
   input wire logic bus_wr,
   input wire logic bus_rd,
   output logic [7:0] bus_rdata,
   input wire logic [2:0] state_in,
   input wire logic auth_done,
   input wire crs_pkg::crs_rx_in_s rx_in,
   output crs_pkg::crs_byte_s byte_out,
   output logic cipher_active,
   output logic irq
);
   import crs_pkg::*;

   // ==========================================================
   // overview
   // host side reaches four byte registers plus two irq registers
   // decoder side delivers one data bit per cycle at most
   // start clears the assembler, the counters and the error flags
   // bits land from the offset upward, position seven wraps to a new byte
   // first collision of a frame fixes the reported position
   // later collisions change nothing, the stored bit values included
   // keep off forces later bits to zero, the collided bit is kept
   // position counts data bits only, offset added in
   // collision as integrity error also raises the integrity flag
   // done flushes a partial byte and, at nonzero offset, loads the valid bit count
   // a bit and done together: bit taken, done must come again
   // every flag gives priority to its setting event over a clear
   // no buffer: each byte is offered once on byte_out for a cycle
   // consumer must take byte_out.data while valid is high
   // host reads answer one cycle later and read zero otherwise

   // ==========================================================
   // storage
   logic [2:0] transceiver_state;        // registered state code
   logic keep_bits_after_collision;      // control bit 7
   logic [2:0] first_bit_offset;         // control bits 6..4
   logic collision_as_integrity_error;   // control bit 3
   logic [2:0] last_byte_valid_bits;     // control bits 2..0
   logic collision_position_valid;       // coll bit 7
   logic [6:0] collision_position;       // coll bits 6..0
   logic collision_detected;             // error bit 2
   logic integrity_error;                // error bit 0
   logic [3:0] irq_status;               // sticky events
   logic [3:0] irq_mask;                 // event enables
   crs_rx_phase_e rx_phase;              // assembler phase
   logic [2:0] bit_pos;                  // next store position in byte
   logic [7:0] assemble;                 // byte under assembly
   logic [7:0] data_count;               // data bits received, saturating
   logic coll_seen;                      // first collision already taken

   // ==========================================================
   // decodes
   // write decodes, one per writable register
   // bit_take ignores bits before start and bits beside start
   logic wr_status;
   logic wr_ctrl;
   logic wr_irq_status;
   logic wr_irq_mask;
   logic bit_take;                       // data bit accepted this cycle
   logic stored_bit;                     // value written into the byte
   logic first_coll;                     // first collision in frame
   logic integ_event;                    // integrity error this cycle
   logic [7:0] next_assemble;            // byte with current bit placed
   logic [7:0] coll_sum;                 // offset plus data index
   logic [3:0] events;                   // event pulses

   assign wr_status = bus_wr && (bus_addr == crs_addr_link_status);
   assign wr_ctrl = bus_wr && (bus_addr == crs_addr_rx_bit_ctrl);
   assign wr_irq_status = bus_wr && (bus_addr == crs_addr_irq_status);
   assign wr_irq_mask = bus_wr && (bus_addr == crs_addr_irq_mask);
   assign bit_take = (rx_phase == crs_rx_active) && rx_in.bit_valid && !rx_in.start;
   assign first_coll = bit_take && rx_in.bit_coll && !coll_seen;

   // ==========================================================
   // bit value selection and placement
   always_comb begin
      // zero forced only for bits after the first collision
      if (coll_seen && !keep_bits_after_collision) begin
         stored_bit = 1'b0;
      end else begin
         stored_bit = rx_in.bit_value;
      end
      next_assemble = assemble;
      next_assemble[bit_pos] = stored_bit;
      // position counts stored placement, offset included
      coll_sum = data_count + {5'h00, first_bit_offset};
   end

   assign integ_event = rx_in.integ_err ||
                        (first_coll && collision_as_integrity_error);

   // ==========================================================
   // transceiver state report
   // sequencer code is copied every cycle
   // unused code would confuse host polling, so it reads idle
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         transceiver_state <= crs_st_idle;
      end else if (state_in == crs_st_unused) begin
         transceiver_state <= crs_st_idle;
      end else begin
         transceiver_state <= state_in;
      end
   end

   // ==========================================================
   // cipher flag: set by authentication only, set beats clear
   // a host write of one is ignored, only the command sets it
   // authentication beside a clearing write leaves it set
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         cipher_active <= 1'b0;
      end else if (auth_done) begin
         cipher_active <= 1'b1;
      end else if (wr_status && !bus_wdata[crs_pos_cipher]) begin
         cipher_active <= 1'b0;
      end
   end

   // ==========================================================
   // host part of the bit control register
   // offset is read at start, at the first collision and at done, keep per bit
   // so rewrite these between frames, not inside one
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         keep_bits_after_collision <= crs_rst_rx_bit_ctrl[crs_pos_keep];
         first_bit_offset <= crs_rst_rx_bit_ctrl[crs_pos_offset_lo +: 3];
         collision_as_integrity_error <= crs_rst_rx_bit_ctrl[crs_pos_coll_integ];
      end else if (wr_ctrl) begin
         keep_bits_after_collision <= bus_wdata[crs_pos_keep];
         first_bit_offset <= bus_wdata[crs_pos_offset_lo +: 3];
         collision_as_integrity_error <= bus_wdata[crs_pos_coll_integ];
      end
   end

   // ==========================================================
   // last byte valid bits: decoder beats host write
   // byte-oriented frames leave the field at zero after start
   // a host write is stored but the next start clears it again
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         last_byte_valid_bits <= crs_rst_rx_bit_ctrl[2:0];
      end else if (rx_in.start) begin
         last_byte_valid_bits <= 3'h0;
      end else if ((rx_phase == crs_rx_active) && rx_in.done && !bit_take) begin
         // bit-oriented only; zero means whole byte
         if (first_bit_offset != 3'h0) begin
            last_byte_valid_bits <= bit_pos;
         end
      end else if (wr_ctrl) begin
         last_byte_valid_bits <= bus_wdata[2:0];
      end
   end

   // ==========================================================
   // receive phase
   // idle ignores stray bits and done pulses from the decoder
   // a new start while active restarts the frame in place
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         rx_phase <= crs_rx_idle;
      end else begin
         case (rx_phase)
            crs_rx_idle: begin
               if (rx_in.start) begin
                  rx_phase <= crs_rx_active;
               end
            end
            crs_rx_active: begin
               // a bit and done together: bit taken, done ignored and must come again
               if (rx_in.done && !bit_take && !rx_in.start) begin
                  rx_phase <= crs_rx_idle;
               end
            end
            default: begin
               rx_phase <= crs_rx_idle;
            end
         endcase
      end
   end

   // ==========================================================
   // bit assembly into bytes
   // bit_pos always names the slot for the next accepted bit
   // bits below the offset in the first byte stay zero
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         bit_pos <= 3'h0;
         assemble <= 8'h00;
         byte_out <= '0;
      end else if (rx_in.start) begin
         bit_pos <= first_bit_offset;
         assemble <= 8'h00;
         byte_out.valid <= 1'b0;
      end else if (bit_take) begin
         if (bit_pos == 3'h7) begin
            // byte full, next bit goes to bit 0 of a new byte
            byte_out.valid <= 1'b1;
            byte_out.data <= next_assemble;
            assemble <= 8'h00;
            bit_pos <= 3'h0;
         end else begin
            byte_out.valid <= 1'b0;
            assemble <= next_assemble;
            bit_pos <= bit_pos + 3'h1;
         end
      end else if ((rx_phase == crs_rx_active) && rx_in.done && (bit_pos != 3'h0)) begin
         // flush the partial last byte
         byte_out.valid <= 1'b1;
         byte_out.data <= assemble;
         assemble <= 8'h00;
         bit_pos <= 3'h0;
      end else begin
         byte_out.valid <= 1'b0;
      end
   end

   // ==========================================================
   // data bit counter and collision position
   // count stops just above the last reportable position,
   // so offset plus count never wraps into a false valid value
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         data_count <= 8'h00;
         coll_seen <= 1'b0;
         collision_position <= 7'h00;
         collision_position_valid <= 1'b0;
      end else if (rx_in.start) begin
         data_count <= 8'h00;
         coll_seen <= 1'b0;
         collision_position <= 7'h00;
         collision_position_valid <= 1'b0;
      end else if (bit_take) begin
         if (data_count <= crs_coll_pos_max) begin
            data_count <= data_count + 8'h01;
         end
         if (first_coll) begin
            coll_seen <= 1'b1;
            if (coll_sum <= crs_coll_pos_max) begin
               collision_position <= coll_sum[6:0];
               collision_position_valid <= 1'b1;
            end else begin
               collision_position_valid <= 1'b0;
            end
         end
      end
   end

   // ==========================================================
   // error flags: cleared at reception start, set wins
   // both flags stay set until the next start, whatever the host does
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         collision_detected <= 1'b0;
         integrity_error <= 1'b0;
      end else begin
         if (first_coll) begin
            collision_detected <= 1'b1;
         end else if (rx_in.start) begin
            collision_detected <= 1'b0;
         end
         // reception is not stopped by this flag
         if (integ_event) begin
            integrity_error <= 1'b1;
         end else if (rx_in.start) begin
            integrity_error <= 1'b0;
         end
      end
   end

   // ==========================================================
   // interrupt status and mask
   // each event is a single-cycle pulse from the same decodes
   // that drive the registers, so status and registers agree
   always_comb begin
      events = 4'h0;
      events[crs_pos_ev_done] = (rx_phase == crs_rx_active) && rx_in.done && !bit_take;
      events[crs_pos_ev_coll] = first_coll;
      events[crs_pos_ev_integ] = integ_event;
      events[crs_pos_ev_byte] = bit_take && (bit_pos == 3'h7);
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         irq_status <= 4'h0;
      end else begin
         // new events win over a write-one clear
         irq_status <= (irq_status & ~(wr_irq_status ? bus_wdata[3:0] : 4'h0)) | events;
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         irq_mask <= crs_rst_irq_mask;
      end else if (wr_irq_mask) begin
         irq_mask <= bus_wdata[3:0];
      end
   end

   // level output, one cycle behind the status bits
   // extra flop keeps irq a clean registered output
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_status & irq_mask);
      end
   end

   // ==========================================================
   // read port, data one cycle after the strobe
   // idle cycles read zero so a stale answer never lingers
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         bus_rdata <= 8'h00;
      end else if (bus_rd) begin
         case (bus_addr)
            crs_addr_error: begin
               bus_rdata <= 8'h00;
               bus_rdata[crs_pos_err_coll] <= collision_detected;
               bus_rdata[crs_pos_err_integ] <= integrity_error;
            end
            crs_addr_link_status: begin
               bus_rdata <= {2'b00, cipher_active, 2'b00, transceiver_state};
            end
            crs_addr_rx_bit_ctrl: begin
               bus_rdata <= {keep_bits_after_collision, first_bit_offset,
                             collision_as_integrity_error, last_byte_valid_bits};
            end
            crs_addr_rx_coll: begin
               // host trusts position only while valid is set
               bus_rdata <= {collision_position_valid, collision_position};
            end
            crs_addr_irq_status: begin
               bus_rdata <= {4'h0, irq_status};
            end
            crs_addr_irq_mask: begin
               bus_rdata <= {4'h0, irq_mask};
            end
            default: begin
               bus_rdata <= 8'h00; // unmapped reads zero
            end
         endcase
      end else begin
         bus_rdata <= 8'h00;
      end
   end

endmodule : crs_rx_status

// [tb/crs_rx_status_asserts.sv]
// checker for the receive status register group
// sees only the ports of crs_rx_status, one clock domain
`timescale 1ns/10ps
module crs_rx_status_chk
   import crs_pkg::*;
(
   input wire logic clock,
   input wire logic nrst,
   input wire logic [7:0] bus_addr,
   input wire logic [7:0] bus_wdata,
   input wire logic bus_wr,
   input wire logic bus_rd,
   input wire logic [7:0] bus_rdata,
   input wire logic [2:0] state_in,
   input wire logic auth_done,
   input wire crs_pkg::crs_rx_in_s rx_in,
   input wire crs_pkg::crs_byte_s byte_out,
   input wire logic cipher_active,
   input wire logic irq
);
   // ==========================================================
   // helpers
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);
   logic rd_ls; // read of link_status
   logic ev; // anything that may set an irq source
   assign rd_ls = bus_rd && bus_addr == crs_addr_link_status;
   assign ev = rx_in.bit_valid | rx_in.done | rx_in.integ_err | bus_wr;
   // ==========================================================
   // properties
   a_read_idle_zero: assert property (!$past(bus_rd) |-> bus_rdata == 8'h00)
      else $error("read data not zero outside answer cycle");
   a_state_code: assert property (rd_ls |=> bus_rdata[2:0] ==
      ($past(state_in, 2) == crs_st_unused ? crs_st_idle : $past(state_in, 2))
      && {bus_rdata[7:6], bus_rdata[4:3]} == 4'h0)
      else $error("state field wrong");
   a_cipher_read: assert property (rd_ls |=> bus_rdata[5] == $past(cipher_active))
      else $error("cipher bit read wrong");
   a_cipher_src: assert property ($rose(cipher_active) |-> $past(auth_done))
      else $error("cipher set without authentication");
   a_cipher_off: assert property (bus_wr && bus_addr == crs_addr_link_status
      && !bus_wdata[5] && !auth_done |=> !cipher_active)
      else $error("cipher not cleared by write zero");
   a_coll_range: assert property (bus_rd && bus_addr == crs_addr_rx_coll
      |=> !bus_rdata[7] || bus_rdata[6:0] <= crs_coll_pos_max[6:0])
      else $error("valid collision position above limit");
   a_byte_cause: assert property (byte_out.valid
      |-> $past(rx_in.bit_valid) || $past(rx_in.done))
      else $error("byte without bit or end");
   a_irq_cause: assert property ($rose(irq) |-> $past(ev, 2) || $past(ev, 3)
      || $past(ev, 4))
      else $error("irq rose without event");
   c_auth: cover property ($rose(cipher_active));
   c_byte: cover property (byte_out.valid);
   c_irq: cover property ($rose(irq));
endmodule : crs_rx_status_chk

bind crs_rx_status crs_rx_status_chk chk_u (.clock, .nrst, .bus_addr, .bus_wdata,
   .bus_wr, .bus_rd, .bus_rdata, .state_in, .auth_done, .rx_in, .byte_out,
   .cipher_active, .irq);

// [tb/crs_rx_src.sv]
// partner model: receive decoder feeding bits into crs_rx_status
// assumes one clock; every change lands just after a rising edge
`timescale 1ns/10ps
module crs_rx_src (
   input wire logic clock,
   output crs_pkg::crs_rx_in_s rx_in
);
   import crs_pkg::*;
   initial rx_in = '0;
   // one frame: start, n bits of value one, then a lone end pulse
   task automatic send(input int n, input int c, input int e);
      @(posedge clock);
      rx_in <= '{1'b1, 1'b0, ~rx_in.bit_value, 1'b0, 1'b0, 1'b0};
      for (int i = 0; i < n; i++) begin
         @(posedge clock);
         rx_in <= '{1'b0, 1'b1, 1'b1, 1'(i == c), 1'(i == e), 1'b0};
      end
      @(posedge clock);
      rx_in <= '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
      @(posedge clock);
      rx_in <= '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
   endtask : send
endmodule : crs_rx_src

// [tb/test_crs_rx_status.sv]
// self-checking bench for crs_rx_status
// assumes crs_rx_src as bit source and the checker bound beside the design
`timescale 1ns/10ps
module test_crs_rx_status;
   import crs_pkg::*;
   logic clock = 1'b0;
   logic nrst = 1'b0;
   logic [7:0] bus_addr = 8'h00;
   logic [7:0] bus_wdata = 8'h00;
   logic bus_wr = 1'b0;
   logic bus_rd = 1'b0;
   logic [7:0] bus_rdata;
   logic [2:0] state_in = 3'h0;
   logic auth_done = 1'b0;
   crs_rx_in_s rx_in;
   crs_byte_s byte_out;
   logic cipher_active;
   logic irq;
   int n_errors = 0;
   int checked = 0;
   logic [7:0] got[$]; // bytes seen at the buffer side
   always #2.5 clock = ~clock;
   crs_rx_status dut_u (.clock(clock), .nrst(nrst), .bus_addr(bus_addr),
      .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
      .state_in(state_in), .auth_done(auth_done), .rx_in(rx_in), .byte_out(byte_out),
      .cipher_active(cipher_active), .irq(irq));
   crs_rx_src src_u (.clock(clock), .rx_in(rx_in));
   always @(negedge clock) if (byte_out.valid === 1'b1) got.push_back(byte_out.data);
   // ==========================================================
   // tasks
   task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
      checked++;
      if (g !== e) begin
         n_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : cmp8
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      bus_addr <= a;
      bus_wdata <= d;
      bus_wr <= 1'b1;
      @(posedge clock);
      bus_wr <= 1'b0;
   endtask : wr
   task automatic chk(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
      @(posedge clock);
      bus_addr <= a;
      bus_rd <= 1'b1;
      @(posedge clock);
      bus_rd <= 1'b0;
      #1 cmp8(bus_rdata & m, e);
   endtask : chk
   task automatic bchk(input logic [7:0] e);
      logic [7:0] g;
      g = 8'hxx;
      if (got.size() != 0) g = got.pop_front();
      cmp8(g, e);
   endtask : bchk
   task automatic frame(input logic [7:0] ctl, input int n, input int c, input int e);
      wr(crs_addr_rx_bit_ctrl, ctl);
      got.delete();
      src_u.send(n, c, e);
      repeat (4) @(posedge clock);
   endtask : frame
   task automatic tally_and_finish();
      if (n_errors == 0 && checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : tally_and_finish
   // ==========================================================
   // watchdog
   initial begin
      #50000;
      n_errors++;
      tally_and_finish();
   end
   // ==========================================================
   // main sequence
   initial begin
      repeat (4) @(posedge clock);
      nrst <= 1'b1;
      chk(crs_addr_rx_bit_ctrl, 8'h00, 8'hff);
      wr(crs_addr_rx_coll, 8'hff);
      chk(crs_addr_rx_coll, 8'h00, 8'hff);
      chk(8'h33, 8'h00, 8'hff);
      for (int i = 0; i < 8; i++) begin
         @(posedge clock);
         state_in <= 3'(i);
         chk(crs_addr_link_status, (i == 4) ? 8'h00 : 8'(i), 8'hff);
      end
      state_in <= 3'h0;
      wr(crs_addr_link_status, 8'h20);
      chk(crs_addr_link_status, 8'h00, 8'hff);
      @(posedge clock);
      auth_done <= 1'b1;
      @(posedge clock);
      auth_done <= 1'b0;
      chk(crs_addr_link_status, 8'h20, 8'hff);
      wr(crs_addr_link_status, 8'h00);
      #1 cmp8({7'h00, cipher_active}, 8'h00);
      wr(crs_addr_irq_mask, 8'h01);
      frame(8'h70, 2, -1, -1);
      bchk(8'h80);
      bchk(8'h01);
      chk(crs_addr_rx_bit_ctrl, 8'h71, 8'hff);
      cmp8({7'h00, irq}, 8'h01);
      chk(crs_addr_irq_status, 8'h09, 8'h0f);
      wr(crs_addr_irq_status, 8'h0f);
      repeat (2) @(posedge clock);
      #1 cmp8({7'h00, irq}, 8'h00);
      frame(8'h48, 6, 3, -1);
      bchk(8'hf0);
      bchk(8'h00);
      chk(crs_addr_rx_bit_ctrl, 8'h4a, 8'hff);
      chk(crs_addr_rx_coll, 8'h87, 8'hff);
      chk(crs_addr_error, 8'h05, 8'h05);
      frame(8'hc7, 12, 3, -1);
      bchk(8'hf0);
      bchk(8'hff);
      chk(crs_addr_rx_bit_ctrl, 8'hc0, 8'hff);
      chk(crs_addr_error, 8'h04, 8'h05);
      frame(8'h00, 64, 63, -1);
      for (int i = 0; i < 8; i++) bchk(8'hff);
      chk(crs_addr_rx_coll, 8'hbf, 8'hff);
      frame(8'h00, 65, 64, -1);
      for (int i = 0; i < 8; i++) bchk(8'hff);
      bchk(8'h01);
      chk(crs_addr_rx_bit_ctrl, 8'h00, 8'hff);
      chk(crs_addr_rx_coll, 8'h00, 8'h80);
      wr(crs_addr_irq_mask, 8'h00);
      wr(crs_addr_irq_status, 8'h0f);
      frame(8'h00, 16, -1, 5);
      bchk(8'hff);
      bchk(8'hff);
      chk(crs_addr_error, 8'h01, 8'h05);
      chk(crs_addr_rx_coll, 8'h00, 8'h80);
      cmp8({7'h00, irq}, 8'h00);
      chk(crs_addr_irq_status, 8'h0d, 8'h0f);
      wr(crs_addr_irq_mask, 8'h04);
      chk(crs_addr_irq_mask, 8'h04, 8'h0f);
      cmp8({7'h00, irq}, 8'h01);
      tally_and_finish();
   end
endmodule : test_crs_rx_status
